// File: rtl/i2c_config_slave.v
// two-wire serial slave giving a bus master access to eight config bytes
`timescale 1ns/1ps
`include "i2c_config_defines.vh"

module i2c_config_slave #(
    parameter [`ADDR_UPPER_W-1:0] ADDR_UPPER = `ADDR_UPPER_DEF
) (
    input  wire                         clock,
    input  wire                         rst_n,
    input  wire                         scl_in,
    output wire                         scl_out,
    output wire                         scl_oe,
    input  wire                         sda_in,
    output wire                         sda_out,
    output wire                         sda_oe,
    input  wire                         slave_addr_sel_lo,
    input  wire                         slave_addr_sel_hi,
    output wire [`CFG_NUM_REGS*8-1:0]   cfg_bytes,
    output wire                         wr_valid,
    input  wire                         wr_ready,
    output wire [`CFG_PTR_W-1:0]        wr_index,
    output wire [`CFG_DATA_W-1:0]       wr_data,
    output wire                         busy
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    // engine states, binary coded
    localparam [`STATE_W-1:0] ST_IDLE      = 4'h0;
    localparam [`STATE_W-1:0] ST_ADDR      = 4'h1;
    localparam [`STATE_W-1:0] ST_ADDR_ACK  = 4'h2;
    localparam [`STATE_W-1:0] ST_PTR       = 4'h3;
    localparam [`STATE_W-1:0] ST_PTR_ACK   = 4'h4;
    localparam [`STATE_W-1:0] ST_WDATA     = 4'h5;
    localparam [`STATE_W-1:0] ST_WSTALL    = 4'h6;
    localparam [`STATE_W-1:0] ST_WDATA_ACK = 4'h7;
    localparam [`STATE_W-1:0] ST_RDATA     = 4'h8;
    localparam [`STATE_W-1:0] ST_RACK      = 4'h9;
    reg                     scl_s1_q;
    reg                     scl_s2_q;
    reg                     scl_p_q;
    reg                     sda_s1_q;
    reg                     sda_s2_q;
    reg                     sda_p_q;
    reg                     sel_lo_s1_q;
    reg                     sel_lo_s2_q;
    reg                     sel_hi_s1_q;
    reg                     sel_hi_s2_q;
    reg [`STATE_W-1:0]      state_q;
    reg [3:0]               cnt_q;
    reg [7:0]               shift_q;
    reg [7:0]               tx_q;
    reg [`CFG_PTR_W-1:0]    ptr_q;
    reg                     sda_oe_q;
    reg                     scl_oe_q;
    reg                     line_low_q;
    reg                     mack_q;
    reg                     busy_q;
    reg [`CFG_DATA_W-1:0]   cfg_mem [0:`CFG_NUM_REGS-1];
    wire                    scl_rise;
    wire                    scl_fall;
    wire                    start_cond;
    wire                    stop_cond;
    wire                    byte_done;
    wire                    addr_match;
    wire                    buf_ready;
    wire                    wr_now;
    wire [`CFG_DATA_W-1:0]  rd_byte;
    wire [`NOTE_W-1:0]      note_out;

    // ------------------------------------------------------------------
    // pin synchronisers: two flops, then a history flop for edges on scl and sda
    // ------------------------------------------------------------------
    // the bus clock is only sampled, so no oscillator is needed
    always @(posedge clock) begin
        if (!rst_n) begin
            scl_s1_q    <= 1'b1;
            scl_s2_q    <= 1'b1;
            scl_p_q     <= 1'b1;
            sda_s1_q    <= 1'b1;
            sda_s2_q    <= 1'b1;
            sda_p_q     <= 1'b1;
            sel_lo_s1_q <= 1'b0;
            sel_lo_s2_q <= 1'b0;
            sel_hi_s1_q <= 1'b0;
            sel_hi_s2_q <= 1'b0;
        end else begin
            scl_s1_q    <= scl_in;
            scl_s2_q    <= scl_s1_q;
            scl_p_q     <= scl_s2_q;
            sda_s1_q    <= sda_in;
            sda_s2_q    <= sda_s1_q;
            sda_p_q     <= sda_s2_q;
            sel_lo_s1_q <= slave_addr_sel_lo;
            sel_lo_s2_q <= sel_lo_s1_q;
            sel_hi_s1_q <= slave_addr_sel_hi;
            sel_hi_s2_q <= sel_hi_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------------
    // both lines share the same latency, so data set-up is preserved
    assign scl_rise   = scl_s2_q & ~scl_p_q;
    assign scl_fall   = ~scl_s2_q & scl_p_q;
    assign start_cond = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
    assign stop_cond  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
    assign byte_done  = scl_fall && (cnt_q == `BITS_PER_BYTE);

    // upper bits fixed; general call (all zero) matches only when ADDR_UPPER is zero and both selects are low
    assign addr_match = (shift_q[7:1] ==
                         {ADDR_UPPER, sel_hi_s2_q, sel_lo_s2_q});

    // a data byte is committed only once fully received and buffer free
    assign wr_now = buf_ready && !start_cond && !stop_cond &&
                    (((state_q == ST_WDATA) && byte_done) ||
                     (state_q == ST_WSTALL));

    assign rd_byte = cfg_mem[ptr_q];

    // ------------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CFG_NUM_REGS; g = g + 1) begin : g_cfg
            // cleared on reset, written whole at the acknowledge
            always @(posedge clock) begin
                if (!rst_n) begin
                    cfg_mem[g] <= `CFG_REG_RESET;
                end else if (wr_now && (ptr_q == g)) begin
                    cfg_mem[g] <= shift_q;
                end
            end
            assign cfg_bytes[g*8 +: 8] = cfg_mem[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------------
    // sda is changed on a falling scl edge, or in ST_WSTALL while the clock is held low
    always @(posedge clock) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 4'h0;
            shift_q  <= 8'h00;
            tx_q     <= 8'h00;
            ptr_q    <= {`CFG_PTR_W{1'b0}};
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            mack_q   <= 1'b0;
        end else if (start_cond) begin
            // also a repeated start; pointer kept
            state_q  <= ST_ADDR;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else if (stop_cond) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s2_q};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        cnt_q <= 4'h0;
                        if (state_q == ST_ADDR) begin
                            if (addr_match) begin
                                sda_oe_q <= 1'b1;
                                mack_q   <= shift_q[`RW_BIT];
                                state_q  <= ST_ADDR_ACK;
                            end else begin
                                state_q  <= ST_IDLE;
                            end
                        end else if (state_q == ST_PTR) begin
                            ptr_q    <= shift_q[`CFG_PTR_W-1:0];
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_PTR_ACK;
                        end else if (wr_now) begin
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_WDATA_ACK;
                        end else begin
                            // buffer full: stretch the clock low
                            scl_oe_q <= 1'b1;
                            state_q  <= ST_WSTALL;
                        end
                    end
                end
                ST_WSTALL: begin
                    // clock still held: freeing it with the data change
                    // would look like a start condition on the bus
                    if (wr_now) begin
                        sda_oe_q <= 1'b1;
                        state_q  <= ST_WDATA_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    // mack_q holds the direction bit here
                    if (scl_fall) begin
                        if (mack_q) begin
                            sda_oe_q <= ~rd_byte[7];
                            tx_q     <= {rd_byte[6:0], 1'b0};
                            cnt_q    <= 4'h1;
                            ptr_q    <= ptr_q + 1'b1;
                            state_q  <= ST_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    scl_oe_q <= 1'b0;
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        ptr_q    <= ptr_q + 1'b1;
                        state_q  <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == `BITS_PER_BYTE) begin
                            // let go for the master's acknowledge slot
                            sda_oe_q <= 1'b0;
                            cnt_q    <= 4'h0;
                            state_q  <= ST_RACK;
                        end else begin
                            sda_oe_q <= ~tx_q[7];
                            tx_q     <= {tx_q[6:0], 1'b0};
                            cnt_q    <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s2_q;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            sda_oe_q <= ~rd_byte[7];
                            tx_q     <= {rd_byte[6:0], 1'b0};
                            cnt_q    <= 4'h1;
                            ptr_q    <= ptr_q + 1'b1;
                            state_q  <= ST_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe_q <= 1'b0;
                    scl_oe_q <= 1'b0;
                    state_q  <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status and constant-low drive levels
    // ------------------------------------------------------------------
    // open-drain: the driven level is always low, only enables move
    always @(posedge clock) begin
        if (!rst_n) begin
            line_low_q <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            line_low_q <= 1'b0;
            busy_q     <= (state_q != ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // write-notice buffer; a full buffer stalls the bus clock
    // ------------------------------------------------------------------
    pair_buffer u_notes (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (wr_now),
        .in_ready  (buf_ready),
        .in_data   ({ptr_q, shift_q}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (note_out)
    );

    assign wr_index = note_out[`NOTE_W-1:`CFG_DATA_W];
    assign wr_data  = note_out[`CFG_DATA_W-1:0];
    assign sda_oe   = sda_oe_q;
    assign sda_out  = line_low_q;
    assign scl_oe   = scl_oe_q;
    assign scl_out  = line_low_q;
    assign busy     = busy_q;

endmodule // i2c_config_slave

// File: rtl/i2c_config_defines.vh
// constants shared by the two-wire configuration slave
`ifndef I2C_CONFIG_DEFINES_VH
`define I2C_CONFIG_DEFINES_VH

// ----------------------------------------------------------------------
// register file shape
// ----------------------------------------------------------------------
`define CFG_NUM_REGS      8
`define CFG_PTR_W         3
`define CFG_DATA_W        8
`define CFG_REG_RESET     8'h00

// ----------------------------------------------------------------------
// slave address layout
// ----------------------------------------------------------------------
`define ADDR_UPPER_W      5
`define ADDR_UPPER_DEF    5'h0B
`define RW_BIT            0

// ----------------------------------------------------------------------
// serial engine
// ----------------------------------------------------------------------
`define BITS_PER_BYTE     4'h8
`define STATE_W           4

// ----------------------------------------------------------------------
// write-notification buffer entry: pointer then data
// ----------------------------------------------------------------------
`define NOTE_W            11

`endif

// File: rtl/pair_buffer.v
// two-entry valid/ready buffer carrying register-write notices
`timescale 1ns/1ps
`include "i2c_config_defines.vh"

module pair_buffer (
    input  wire                 clock,
    input  wire                 rst_n,
    input  wire                 in_valid,
    output wire                 in_ready,
    input  wire [`NOTE_W-1:0]   in_data,
    output wire                 out_valid,
    input  wire                 out_ready,
    output wire [`NOTE_W-1:0]   out_data
);

    reg                 valid0_q;
    reg                 valid1_q;
    reg [`NOTE_W-1:0]   entry0_q;
    reg [`NOTE_W-1:0]   entry1_q;
    wire                push;
    wire                pop;

    // full only when the second slot holds a word
    assign in_ready  = ~valid1_q;
    assign out_valid = valid0_q;
    assign out_data  = entry0_q;
    assign push      = in_valid & ~valid1_q;
    assign pop       = valid0_q & out_ready;

    // ------------------------------------------------------------------
    // head is entry0; entry1 shifts down on a pop
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            valid0_q <= 1'b0;
            valid1_q <= 1'b0;
            entry0_q <= {`NOTE_W{1'b0}};
            entry1_q <= {`NOTE_W{1'b0}};
        end else begin
            if (push && pop) begin
                if (valid1_q) begin
                    entry0_q <= entry1_q;
                    entry1_q <= in_data;
                end else begin
                    entry0_q <= in_data;
                end
            end else if (pop) begin
                entry0_q <= entry1_q;
                valid0_q <= valid1_q;
                valid1_q <= 1'b0;
            end else if (push) begin
                if (valid0_q) begin
                    entry1_q <= in_data;
                    valid1_q <= 1'b1;
                end else begin
                    entry0_q <= in_data;
                    valid0_q <= 1'b1;
                end
            end
        end
    end

endmodule // pair_buffer

// File: testbench/i2c_config_slave_monitor.sv
// assertion checker for the two-wire configuration slave
`timescale 1ns/1ps
`include "i2c_config_defines.vh"

module i2c_config_slave_monitor (
    input wire                       clock,
    input wire                       rst_n,
    input wire                       scl_in,
    input wire                       scl_out,
    input wire                       scl_oe,
    input wire                       sda_in,
    input wire                       sda_out,
    input wire                       sda_oe,
    input wire                       slave_addr_sel_lo,
    input wire                       slave_addr_sel_hi,
    input wire [`CFG_NUM_REGS*8-1:0] cfg_bytes,
    input wire                       wr_valid,
    input wire                       wr_ready,
    input wire [`CFG_PTR_W-1:0]      wr_index,
    input wire [`CFG_DATA_W-1:0]     wr_data,
    input wire                       busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // bus events and checks
    // ------------------------------------------------------------
    sequence start_seen;
        scl_in && $fell(sda_in);
    endsequence
    sequence stop_seen;
        scl_in && $rose(sda_in);
    endsequence
    sequence ack_high;
        sda_oe && $rose(scl_in);
    endsequence

    // reset itself must be checked, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> !sda_oe && !scl_oe && !wr_valid && !busy && cfg_bytes == 64'h0)
        else $error("outputs not quiet after reset");
    a_start_wakes: assert property (start_seen |-> ##[2:6] busy)
        else $error("start not seen");
    a_stop_idles: assert property (stop_seen |-> ##[2:6] !busy)
        else $error("stop not seen");
    a_drive_low_only: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
        else $error("data line taken while clock high");
    a_ack_holds: assert property (ack_high |=> sda_oe [*3])
        else $error("low level dropped during clock high");
    a_pins_pull_low: assert property ((sda_oe || scl_oe) |-> !sda_out && !scl_out)
        else $error("pin driven high");
    a_update_noted: assert property ($changed(cfg_bytes) |-> ##[0:2] wr_valid)
        else $error("register update without notice");
    a_update_on_ack: assert property ($changed(cfg_bytes) |-> ##[0:3] sda_oe)
        else $error("register update away from acknowledge");
    a_notice_holds: assert property (wr_valid && !wr_ready |=>
        wr_valid && $stable({wr_index, wr_data}))
        else $error("notice changed before taken");
    a_stretch_full: assert property (scl_oe |-> wr_valid)
        else $error("clock held with no pending notice");
    a_release_apart: assert property ($fell(scl_oe) |-> $stable(sda_oe))
        else $error("data line moved as the clock was freed");
endmodule // i2c_config_slave_monitor

bind i2c_config_slave i2c_config_slave_monitor u_mon (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .slave_addr_sel_lo(slave_addr_sel_lo), .slave_addr_sel_hi(slave_addr_sel_hi),
    .cfg_bytes(cfg_bytes), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_index(wr_index), .wr_data(wr_data), .busy(busy)
);

// File: testbench/i2c_master_model.sv
// bus master model driving the two-wire link at a 200 ns bit period
`timescale 1ns/1ps

module i2c_master_model (
    input  wire logic clock,
    input  wire logic scl_w,
    input  wire logic sda_w,
    output logic      scl_m,
    output logic      sda_m
);
    integer hangs = 0;

    // ------------------------------------------------------------
    // bit, byte and framing tasks
    // ------------------------------------------------------------
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end

    // one bit: data set mid-low, sampled while the clock is high
    task clk_bit(input logic b, output logic r);
        integer n;
        repeat (2) @(posedge clock);
        sda_m <= b;
        repeat (2) @(posedge clock);
        scl_m <= 1'b1;
        n = 0;
        // a stretching slave holds the clock low; bounded so a hang shows
        while (scl_w !== 1'b1 && n < 4000) begin
            @(posedge clock);
            n = n + 1;
        end
        if (n >= 4000) hangs = hangs + 1;
        @(posedge clock);
        r = sda_w;
        repeat (2) @(posedge clock);
        scl_m <= 1'b0;
    endtask

    // also a repeated start: data released before the clock rises
    task send_start();
        @(posedge clock);
        sda_m <= 1'b1;
        repeat (4) @(posedge clock);
        scl_m <= 1'b1;
        repeat (4) @(posedge clock);
        sda_m <= 1'b0;
        repeat (4) @(posedge clock);
        scl_m <= 1'b0;
    endtask

    task send_stop();
        repeat (2) @(posedge clock);
        sda_m <= 1'b0;
        repeat (2) @(posedge clock);
        scl_m <= 1'b1;
        repeat (4) @(posedge clock);
        sda_m <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask

    // low after a byte asks for more, high ends the read
    task rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(last, r);
    endtask
endmodule // i2c_master_model

// File: testbench/tb_top.sv
// self-checking bench for the two-wire configuration slave
`timescale 1ns/1ps
`include "i2c_config_defines.vh"

`define check_eq(got, exp) \
    begin \
        n_compared = n_compared + 1; \
        if ((got) !== (exp)) begin \
            miscompares = miscompares + 1; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module tb_top;
    logic                        clock;
    logic                        rst_n;
    logic                        slave_addr_sel_lo;
    logic                        slave_addr_sel_hi;
    logic                        wr_ready;
    logic                        hold_ready;
    logic                        scl_m;
    logic                        sda_m;
    wire                         scl_out;
    wire                         scl_oe;
    wire                         sda_out;
    wire                         sda_oe;
    wire [`CFG_NUM_REGS*8-1:0]   cfg_bytes;
    wire                         wr_valid;
    wire [`CFG_PTR_W-1:0]        wr_index;
    wire [`CFG_DATA_W-1:0]       wr_data;
    wire                         busy;
    logic [15:0]                 seed;
    logic [15:0]                 sink_seed;
    logic [6:0]                  dev;
    logic [7:0]                  exp_cfg [8];
    logic [10:0]                 exp_q [$];
    logic [10:0]                 note;
    integer                      miscompares = 0;
    integer                      n_compared = 0;

    // ------------------------------------------------------------
    // wires with pull-ups, design, partner
    // ------------------------------------------------------------
    wire scl_in = scl_m & (scl_oe ? scl_out : 1'b1);
    wire sda_in = sda_m & (sda_oe ? sda_out : 1'b1);

    i2c_config_slave u_dut (
        .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .slave_addr_sel_lo(slave_addr_sel_lo), .slave_addr_sel_hi(slave_addr_sel_hi),
        .cfg_bytes(cfg_bytes), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_index(wr_index), .wr_data(wr_data), .busy(busy)
    );

    i2c_master_model u_master (
        .clock(clock), .scl_w(scl_in), .sda_w(sda_in), .scl_m(scl_m), .sda_m(sda_m)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // sink: random readiness, or held off so the buffer fills
    always @(posedge clock) begin
        sink_seed <= lfsr(sink_seed);
        wr_ready <= !hold_ready && sink_seed[0];
    end

    // each taken notice must match the oldest expected write
    always @(posedge clock) begin
        if (rst_n && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 11'h7FF;
            `check_eq({wr_index, wr_data}, note)
        end
    end

    task conclude();
        miscompares = miscompares + u_master.hangs;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check_cfg();
        for (int i = 0; i < 8; i++) `check_eq(cfg_bytes[8*i +: 8], exp_cfg[i])
    endtask

    task write_regs(input logic [6:0] addr, input logic [2:0] ptr, input int n, input logic want);
        logic       ack;
        logic [7:0] d;
        u_master.send_start();
        u_master.wbyte({addr, 1'b0}, ack);
        `check_eq(ack, want)
        if (ack) begin
            u_master.wbyte({seed[15:11], ptr}, ack);
            for (int i = 0; i < n; i++) begin
                seed = lfsr(seed);
                d = seed[7:0];
                exp_q.push_back({ptr, d});
                exp_cfg[ptr] = d;
                u_master.wbyte(d, ack);
                `check_eq(ack, 1'b1)
                ptr = ptr + 3'h1;
            end
        end
        u_master.send_stop();
    endtask

    task read_regs(input logic [2:0] ptr, input int n);
        logic       ack;
        logic [7:0] d;
        u_master.send_start();
        u_master.wbyte({dev, 1'b0}, ack);
        u_master.wbyte({5'h00, ptr}, ack);
        u_master.send_start();
        u_master.wbyte({dev, 1'b1}, ack);
        `check_eq(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            u_master.rbyte(i == n - 1, d);
            `check_eq(d, exp_cfg[ptr])
            ptr = ptr + 3'h1;
        end
        u_master.send_stop();
    endtask

    // a data byte cut short by a stop or a repeated start
    task abort_write(input logic [2:0] ptr, input int bits, input logic restart);
        logic r;
        u_master.send_start();
        u_master.wbyte({dev, 1'b0}, r);
        u_master.wbyte({5'h00, ptr}, r);
        for (int i = 0; i < bits; i++) u_master.clk_bit(i[0], r);
        if (restart) u_master.send_start();
        u_master.send_stop();
    endtask

    initial begin
        repeat (90000) @(posedge clock);
        miscompares = miscompares + 1;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        hold_ready = 1'b0;
        wr_ready = 1'b0;
        {slave_addr_sel_hi, slave_addr_sel_lo} = 2'b10;
        seed = 16'h5436;
        sink_seed = 16'h5436;
        dev = {`ADDR_UPPER_DEF, 2'b10};
        for (int i = 0; i < 8; i++) exp_cfg[i] = 8'h00;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        check_cfg();
        write_regs(dev, 3'h3, 1, 1'b1);
        check_cfg();
        read_regs(3'h3, 1);
        hold_ready <= 1'b1;
        fork
            begin
                repeat (400) @(posedge clock);
                hold_ready <= 1'b0;
            end
        join_none
        write_regs(dev, 3'h6, 10, 1'b1);
        check_cfg();
        read_regs(3'h5, 9);
        write_regs(dev ^ 7'h01, 3'h0, 1, 1'b0);
        write_regs(7'h00, 3'h0, 1, 1'b0);
        abort_write(3'h2, 4, 1'b0);
        abort_write(3'h4, 7, 1'b1);
        check_cfg();
        {slave_addr_sel_hi, slave_addr_sel_lo} <= 2'b01;
        dev = {`ADDR_UPPER_DEF, 2'b01};
        repeat (8) @(posedge clock);
        write_regs(dev, 3'h1, 2, 1'b1);
        read_regs(3'h0, 8);
        repeat (20) @(posedge clock);
        `check_eq(exp_q.size(), 0)
        conclude();
    end
endmodule // tb_top
